// file: design/drvms_perm.sv
// Permission decoder: start mode and allowed switches from the settings.
// Assumes settings already filtered to legal codes; purely combinational.
`timescale 1ns/1ps
module drvms_perm (
  input  wire logic [2:0] i_sel,
  input  wire logic [3:0] i_startup,
  input  wire logic       i_lock,
  output logic      [1:0] o_init_mode,
  output logic            o_ext_panel,
  output logic            o_ext_net,
  output logic            o_panel_net,
  output logic            o_run_ok,
  output logic            o_force_ext
);

  logic s_net;
  logic s_pn;

  // ************************************************************
  // Decode table
  // ************************************************************
  // Startup code groups select the start mode within selections 0, 2, 6 and 7
  always_comb begin
    s_net       = (i_startup == drvms_pkg::SU_NET_A) || (i_startup == drvms_pkg::SU_NET_B); // RULE2
    s_pn        = (i_startup == drvms_pkg::SU_PN_A) || (i_startup == drvms_pkg::SU_PN_B);
    o_init_mode = drvms_pkg::DRVMS_EXT;
    o_ext_panel = 1'b0;
    o_ext_net   = 1'b0;
    o_panel_net = 1'b0;
    o_run_ok    = 1'b0;
    o_force_ext = 1'b0;
    case (i_sel)
      drvms_pkg::SEL_0, drvms_pkg::SEL_6: begin
        o_run_ok = (i_sel == drvms_pkg::SEL_6); // RULE11
        if (s_pn) begin
          o_init_mode = drvms_pkg::DRVMS_NET; // RULE14
          o_panel_net = 1'b1; // RULE14
        end else begin
          o_init_mode = s_net ? drvms_pkg::DRVMS_NET : drvms_pkg::DRVMS_EXT; // RULE6 RULE13
          o_ext_panel = 1'b1;
          o_ext_net   = 1'b1;
        end
      end
      drvms_pkg::SEL_1: o_init_mode = drvms_pkg::DRVMS_PANEL; // RULE8
      drvms_pkg::SEL_2: begin
        o_init_mode = (s_pn || s_net) ? drvms_pkg::DRVMS_NET : drvms_pkg::DRVMS_EXT; // RULE9 RULE15
        o_ext_net   = !s_pn;
      end
      drvms_pkg::SEL_3, drvms_pkg::SEL_4: o_init_mode = drvms_pkg::DRVMS_COMB; // RULE10
      drvms_pkg::SEL_7: begin
        o_init_mode = (s_net && i_lock) ? drvms_pkg::DRVMS_NET : drvms_pkg::DRVMS_EXT; // RULE13
        o_ext_panel = i_lock; // RULE12
        o_ext_net   = i_lock;
        o_force_ext = !i_lock;
      end
      default: o_init_mode = drvms_pkg::DRVMS_EXT;
    endcase
  end

endmodule : drvms_perm

// file: design/drvms_pkg.sv
// Constants, types and helpers of the drive operation-mode selector.
// Assumes one 50 MHz clock and a register port with byte addresses.
package drvms_pkg;

  // ************************************************************
  // Register map and field layout
  // ************************************************************
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam logic [7:0]  OFS_MODE_SEL  = 8'h00;
  localparam logic [7:0]  OFS_STARTUP   = 8'h04;
  localparam logic [7:0]  OFS_COAST     = 8'h08;
  localparam logic [7:0]  OFS_CMD       = 8'h0C;
  localparam logic [7:0]  OFS_STATUS    = 8'h10;
  localparam int          ST_MODE_LSB   = 0;
  localparam int          ST_START_LSB  = 4;
  localparam int          ST_EXT_PANEL  = 8;
  localparam int          ST_EXT_NET    = 9;
  localparam int          ST_PANEL_NET  = 10;
  localparam int          ST_RUN_OK     = 11;
  localparam int          ST_FORCE_EXT  = 12;
  localparam int          ST_START_MASK = 13;
  localparam int          ST_REFUSED    = 14;

  // ************************************************************
  // Setting codes and reset values
  // ************************************************************
  localparam logic [2:0]  SEL_RST       = 3'h0;
  localparam logic [3:0]  STARTUP_RST   = 4'h0;
  localparam logic [15:0] COAST_RST     = 16'h270F;
  localparam logic [15:0] COAST_NO_RST  = 16'h270F;
  localparam logic [2:0]  SEL_0         = 3'h0;
  localparam logic [2:0]  SEL_1         = 3'h1;
  localparam logic [2:0]  SEL_2         = 3'h2;
  localparam logic [2:0]  SEL_3         = 3'h3;
  localparam logic [2:0]  SEL_4         = 3'h4;
  localparam logic [2:0]  SEL_5         = 3'h5;
  localparam logic [2:0]  SEL_6         = 3'h6;
  localparam logic [2:0]  SEL_7         = 3'h7;
  localparam logic [3:0]  SU_NET_A      = 4'h1;
  localparam logic [3:0]  SU_NET_B      = 4'h2;
  localparam logic [3:0]  SU_PN_A       = 4'hA;
  localparam logic [3:0]  SU_PN_B       = 4'hC;

  typedef enum logic [1:0] {
    DRVMS_EXT   = 2'b00,
    DRVMS_PANEL = 2'b01,
    DRVMS_NET   = 2'b10,
    DRVMS_COMB  = 2'b11
  } drvms_mode_t;

  typedef enum logic {
    DRVMS_ST_INIT = 1'b0,
    DRVMS_ST_RUN  = 1'b1
  } drvms_state_t;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic drvms_sel_legal(input logic [2:0] sel);
    drvms_sel_legal = (sel != SEL_5);
  endfunction : drvms_sel_legal

  function automatic logic drvms_startup_legal(input logic [3:0] su);
    drvms_startup_legal = (su == STARTUP_RST) || (su == SU_NET_A) || (su == SU_NET_B) ||
                          (su == SU_PN_A) || (su == SU_PN_B);
  endfunction : drvms_startup_legal

  // Single step between two modes; combined mode never moves
  function automatic logic drvms_step_ok(input logic [1:0] cur, input logic [1:0] tgt,
                                         input logic ep, input logic en, input logic pn);
    logic [3:0] pair;
    pair = {cur, tgt};
    case (pair)
      {DRVMS_EXT, DRVMS_PANEL}, {DRVMS_PANEL, DRVMS_EXT}: drvms_step_ok = ep;
      {DRVMS_EXT, DRVMS_NET},   {DRVMS_NET, DRVMS_EXT}:   drvms_step_ok = en;
      {DRVMS_PANEL, DRVMS_NET}, {DRVMS_NET, DRVMS_PANEL}: drvms_step_ok = pn;
      default:                                            drvms_step_ok = 1'b0;
    endcase
  endfunction : drvms_step_ok

endpackage : drvms_pkg

// file: design/drvms_start_gate.sv
// Start command gate: blanks start inputs held across a power restoration.
// Assumes start inputs synchronous to i_mclk.
`timescale 1ns/1ps
module drvms_start_gate (
  input  wire logic i_mclk,
  input  wire logic i_resetn,
  input  wire logic i_arm,
  input  wire logic i_fwd,
  input  wire logic i_rev,
  output logic      o_fwd,
  output logic      o_rev,
  output logic      o_masked
);

  logic mask_reg;
  logic mask_next;
  logic fwd_reg;
  logic fwd_next;
  logic rev_reg;
  logic rev_next;

  // ************************************************************
  // Mask and gated outputs
  // ************************************************************
  // Mask lifts only once both inputs drop; arming wins over release
  always_comb begin
    mask_next = mask_reg;
    if (!i_fwd && !i_rev) begin
      mask_next = 1'b0;
    end
    if (i_arm) begin
      mask_next = 1'b1; // RULE17
    end
    fwd_next = i_fwd && !mask_next;
    rev_next = i_rev && !mask_next;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      mask_reg <= 1'b0;
      fwd_reg  <= 1'b0;
      rev_reg  <= 1'b0;
    end else begin
      mask_reg <= mask_next;
      fwd_reg  <= fwd_next;
      rev_reg  <= rev_next;
    end
  end

  assign o_fwd    = fwd_reg;
  assign o_rev    = rev_reg;
  assign o_masked = mask_reg;

endmodule : drvms_start_gate

// file: design/drvms_top.sv
// Operation-mode selector of a drive with a fieldbus option: top level.
// Assumes synchronous inputs, one clock, and a one-cycle strobe register port.
// Functional notes
// RULE1: Master stops drive and start inputs before switching.
// RULE2: Nonzero startup setting enters network mode.
// RULE3: Network mode started enables network parameter writes.
// RULE4: Startup setting change applies only at reset.
// RULE5: Startup setting writable from panel in any mode.
// RULE6: Startup 0, selection 0: external, three-way.
// RULE7: No direct panel to network step.
// RULE8: Selection 1: panel mode, locked.
// RULE9: Selection 2: external, external-network only.
// RULE10: Selection 3 or 4: combined, locked.
// RULE11: Selection 6: three-way even while running.
// RULE12: Selection 7: lock on three-way, else external.
// RULE13: Startup 1/2 start network; lock decides for 7.
// RULE14: Startup 10/12, selection 0: panel-network switching.
// RULE15: Startup 10/12: sel 2 locked network, 7 external.
// RULE16: Panel key or link switch input performs switch.
// RULE17: Startup 1/10 drops start held over outage.
// RULE18: Coast time not 9999 resumes previous state.
// RULE19: Configure communication before nonzero startup setting.
// RULE20: Disallowed switch request ignored, mode kept.
`timescale 1ns/1ps
module drvms_top (
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_forward_start_input,
  input  wire logic        i_reverse_start_input,
  input  wire logic        i_motor_running,
  input  wire logic        i_mode_lock_input,
  input  wire logic        i_panel_link_switch_input,
  input  wire logic        i_panel_key,
  input  wire logic        i_panel_startup_wr,
  input  wire logic [3:0]  i_panel_startup_data,
  input  wire logic        i_power_restored,
  output logic      [1:0]  o_mode,
  output logic             o_net_param_wr_en,
  output logic             o_forward_start,
  output logic             o_reverse_start,
  output logic             o_switch_refused
);

  drvms_pkg::drvms_state_t state_reg;
  drvms_pkg::drvms_state_t state_next;
  logic [1:0]  mode_reg;
  logic [1:0]  mode_next;
  logic [2:0]  sel_reg;
  logic [2:0]  sel_next;
  logic [3:0]  startup_reg;
  logic [3:0]  startup_next;
  logic [3:0]  active_reg;
  logic [3:0]  active_next;
  logic [15:0] coast_reg;
  logic [15:0] coast_next;
  logic        refused_reg;
  logic        refused_next;
  logic        link_prev_reg;
  logic        netwr_reg;
  logic        netwr_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [3:0]  perm_startup;
  logic [1:0]  init_mode;
  logic        ok_ext_panel;
  logic        ok_ext_net;
  logic        ok_panel_net;
  logic        ok_run;
  logic        force_ext;
  logic        start_mask;
  logic        gate_arm;
  logic        req_valid;
  logic [1:0]  req_tgt;
  logic        motion_ok;
  logic        cmd_wr;

  // ************************************************************
  // Submodules
  // ************************************************************
  // During evaluation the pending setting is used, afterwards the latched one
  assign perm_startup = (state_reg == drvms_pkg::DRVMS_ST_INIT) ? startup_reg : active_reg; // RULE4

  drvms_perm u_perm (
    .i_sel       (sel_reg),
    .i_startup   (perm_startup),
    .i_lock      (i_mode_lock_input),
    .o_init_mode (init_mode),
    .o_ext_panel (ok_ext_panel),
    .o_ext_net   (ok_ext_net),
    .o_panel_net (ok_panel_net),
    .o_run_ok    (ok_run),
    .o_force_ext (force_ext)
  );

  // Arm on restoration with the startup code in force before the outage
  assign gate_arm = i_power_restored &&
                    ((active_reg == drvms_pkg::SU_NET_A) || (active_reg == drvms_pkg::SU_PN_A)); // RULE17

  drvms_start_gate u_gate (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_arm    (gate_arm),
    .i_fwd    (i_forward_start_input),
    .i_rev    (i_reverse_start_input),
    .o_fwd    (o_forward_start),
    .o_rev    (o_reverse_start),
    .o_masked (start_mask)
  );

  // ************************************************************
  // Settings registers
  // ************************************************************
  // Illegal codes are dropped so the decoder only sees table entries
  always_comb begin
    sel_next     = sel_reg;
    startup_next = startup_reg;
    coast_next   = coast_reg;
    if (i_wr && (i_addr == drvms_pkg::OFS_MODE_SEL) && drvms_pkg::drvms_sel_legal(i_wdata[2:0])) begin
      sel_next = i_wdata[2:0];
    end
    if (i_panel_startup_wr && drvms_pkg::drvms_startup_legal(i_panel_startup_data)) begin
      startup_next = i_panel_startup_data; // RULE5
    end
    if (i_wr && (i_addr == drvms_pkg::OFS_STARTUP) && drvms_pkg::drvms_startup_legal(i_wdata[3:0])) begin
      startup_next = i_wdata[3:0]; // RULE5
    end
    if (i_wr && (i_addr == drvms_pkg::OFS_COAST)) begin
      coast_next = i_wdata[15:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      sel_reg     <= drvms_pkg::SEL_RST;
      startup_reg <= drvms_pkg::STARTUP_RST;
      coast_reg   <= drvms_pkg::COAST_RST;
    end else begin
      sel_reg     <= sel_next;
      startup_reg <= startup_next;
      coast_reg   <= coast_next;
    end
  end

  // ************************************************************
  // Switch requests
  // ************************************************************
  // One request per cycle: software command, then panel key, then link switch
  always_comb begin
    cmd_wr    = i_wr && (i_addr == drvms_pkg::OFS_CMD);
    req_valid = 1'b1;
    req_tgt   = i_wdata[1:0];
    if (cmd_wr) begin
      req_tgt = i_wdata[1:0];
    end else if (i_panel_key) begin
      req_tgt = (mode_reg == drvms_pkg::DRVMS_PANEL) ? drvms_pkg::DRVMS_NET : drvms_pkg::DRVMS_PANEL; // RULE16
    end else if (i_panel_link_switch_input != link_prev_reg) begin
      req_tgt = i_panel_link_switch_input ? drvms_pkg::DRVMS_PANEL : drvms_pkg::DRVMS_NET; // RULE16
    end else begin
      req_valid = 1'b0;
    end
    // Requires the motor stopped and both start inputs off unless running switches are allowed
    motion_ok = ok_run || (!i_motor_running && !i_forward_start_input && !i_reverse_start_input); // RULE1
  end

  // ************************************************************
  // Mode state machine
  // ************************************************************
  // Restoration re-evaluates only when automatic restart is off
  always_comb begin
    state_next   = state_reg;
    mode_next    = mode_reg;
    active_next  = active_reg;
    refused_next = refused_reg;
    case (state_reg)
      drvms_pkg::DRVMS_ST_INIT: begin
        active_next = startup_reg; // RULE4
        mode_next   = init_mode; // RULE2
        state_next  = drvms_pkg::DRVMS_ST_RUN;
      end
      drvms_pkg::DRVMS_ST_RUN: begin
        if (i_power_restored) begin
          if (coast_reg == drvms_pkg::COAST_NO_RST) begin // RULE18
            state_next = drvms_pkg::DRVMS_ST_INIT;
          end
        end else if (force_ext) begin
          mode_next = drvms_pkg::DRVMS_EXT; // RULE12
        end else if (req_valid) begin
          if ((req_tgt == mode_reg) ||
              (drvms_pkg::drvms_step_ok(mode_reg, req_tgt, ok_ext_panel, ok_ext_net, ok_panel_net) &&
               motion_ok)) begin // RULE7
            mode_next    = req_tgt;
            refused_next = 1'b0;
          end else begin
            refused_next = 1'b1; // RULE20
          end
        end
      end
      default: state_next = drvms_pkg::DRVMS_ST_INIT;
    endcase
    netwr_next = (mode_next == drvms_pkg::DRVMS_NET) && (state_next == drvms_pkg::DRVMS_ST_RUN); // RULE3
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      state_reg     <= drvms_pkg::DRVMS_ST_INIT;
      mode_reg      <= drvms_pkg::DRVMS_EXT;
      active_reg    <= drvms_pkg::STARTUP_RST;
      refused_reg   <= 1'b0;
      link_prev_reg <= 1'b0;
      netwr_reg     <= 1'b0;
    end else begin
      state_reg     <= state_next;
      mode_reg      <= mode_next;
      active_reg    <= active_next;
      refused_reg   <= refused_next;
      link_prev_reg <= i_panel_link_switch_input;
      netwr_reg     <= netwr_next;
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************
  // Data stand one cycle only; unmapped addresses read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        drvms_pkg::OFS_MODE_SEL: rdata_next[2:0] = sel_reg;
        drvms_pkg::OFS_STARTUP:  rdata_next[3:0] = startup_reg;
        drvms_pkg::OFS_COAST:    rdata_next[15:0] = coast_reg;
        drvms_pkg::OFS_STATUS: begin
          rdata_next[drvms_pkg::ST_MODE_LSB +: 2]  = mode_reg;
          rdata_next[drvms_pkg::ST_START_LSB +: 4] = active_reg;
          rdata_next[drvms_pkg::ST_EXT_PANEL]      = ok_ext_panel;
          rdata_next[drvms_pkg::ST_EXT_NET]        = ok_ext_net;
          rdata_next[drvms_pkg::ST_PANEL_NET]      = ok_panel_net;
          rdata_next[drvms_pkg::ST_RUN_OK]         = ok_run;
          rdata_next[drvms_pkg::ST_FORCE_EXT]      = force_ext;
          rdata_next[drvms_pkg::ST_START_MASK]     = start_mask;
          rdata_next[drvms_pkg::ST_REFUSED]        = refused_reg;
        end
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata           = rdata_reg;
  assign o_mode            = mode_reg;
  assign o_net_param_wr_en = netwr_reg;
  assign o_switch_refused  = refused_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  logic in_run;
  assign in_run = (state_reg == drvms_pkg::DRVMS_ST_RUN) && !i_power_restored;

  init_ext_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE6
    (state_reg == drvms_pkg::DRVMS_ST_INIT) && (startup_reg == 4'h0) && (sel_reg == drvms_pkg::SEL_0)
    |=> (mode_reg == drvms_pkg::DRVMS_EXT) && (active_reg == 4'h0))
    else $error("startup 0 sel 0 did not enter external mode");

  init_net_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE13
    (state_reg == drvms_pkg::DRVMS_ST_INIT) && ((startup_reg == 4'h1) || (startup_reg == 4'hA)) &&
    ((sel_reg == drvms_pkg::SEL_0) || (sel_reg == drvms_pkg::SEL_2) || (sel_reg == drvms_pkg::SEL_6))
    |=> (mode_reg == drvms_pkg::DRVMS_NET) ##1 o_net_param_wr_en || (mode_reg != drvms_pkg::DRVMS_NET))
    else $error("network start mode not entered");

  netwr_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE3
    $rose(mode_reg == drvms_pkg::DRVMS_NET) && (state_reg == drvms_pkg::DRVMS_ST_RUN) |-> o_net_param_wr_en)
    else $error("network parameter writes not enabled in network mode");

  hold_startup_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE4
    in_run |=> $stable(active_reg))
    else $error("startup setting applied outside reset");

  no_direct_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE7
    in_run && (mode_reg == drvms_pkg::DRVMS_PANEL) && !ok_panel_net |=> (mode_reg != drvms_pkg::DRVMS_NET))
    else $error("direct panel to network step taken");

  locked_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE10
    in_run && !ok_ext_panel && !ok_ext_net && !ok_panel_net && !force_ext |=> $stable(mode_reg))
    else $error("mode moved while switching is locked");

  force_ext_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE12
    in_run && force_ext |=> (mode_reg == drvms_pkg::DRVMS_EXT))
    else $error("lock input off did not force external mode");

  refuse_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE20
    in_run && !force_ext && cmd_wr && (i_wdata[1:0] == drvms_pkg::DRVMS_COMB) &&
    (mode_reg != drvms_pkg::DRVMS_COMB) |=> $stable(mode_reg) && o_switch_refused)
    else $error("refused request changed the mode");

  resume_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE18
    (state_reg == drvms_pkg::DRVMS_ST_RUN) && i_power_restored && (coast_reg != 16'h270F)
    |=> $stable(mode_reg) && (state_reg == drvms_pkg::DRVMS_ST_RUN))
    else $error("restart enabled but state not resumed");

  start_drop_a: assert property (@(posedge i_mclk) disable iff (!i_resetn) // RULE17
    gate_arm |=> !o_forward_start && !o_reverse_start && start_mask)
    else $error("start command survived power restoration");

  run_switch_c: cover property (@(posedge i_mclk) disable iff (!i_resetn)
    in_run && ok_run && i_motor_running ##1 $changed(mode_reg));
  key_switch_c: cover property (@(posedge i_mclk) disable iff (!i_resetn)
    in_run && i_panel_key && ok_panel_net ##1 $changed(mode_reg));
  reinit_c: cover property (@(posedge i_mclk) disable iff (!i_resetn)
    i_power_restored && (state_reg == drvms_pkg::DRVMS_ST_RUN) ##1 (state_reg == drvms_pkg::DRVMS_ST_INIT));

endmodule : drvms_top

// file: tb/drvms_bench.sv
// Self-checking bench of the drive operation-mode selector.
// Assumes the design files and the panel model are compiled first.
`timescale 1ns/1ps
module drvms_bench;
  logic        i_mclk, i_resetn, i_wr, i_rd, i_power_restored;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, o_rdata, rdv;
  logic [1:0]  o_mode;
  logic        o_net_param_wr_en, o_forward_start, o_reverse_start, o_switch_refused;
  logic        fwd, rev, run, lock, link, key, su_wr;
  logic [3:0]  su_data;
  int          n_errors = 0;
  int          checks = 0;

  drvms_top i_dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_forward_start_input(fwd),
    .i_reverse_start_input(rev), .i_motor_running(run), .i_mode_lock_input(lock),
    .i_panel_link_switch_input(link), .i_panel_key(key), .i_panel_startup_wr(su_wr),
    .i_panel_startup_data(su_data), .i_power_restored(i_power_restored), .o_mode(o_mode),
    .o_net_param_wr_en(o_net_param_wr_en), .o_forward_start(o_forward_start),
    .o_reverse_start(o_reverse_start), .o_switch_refused(o_switch_refused));
  drvms_panel_model i_panel (.i_mclk(i_mclk), .o_fwd(fwd), .o_rev(rev), .o_run(run),
    .o_lock(lock), .o_link(link), .o_key(key), .o_su_wr(su_wr), .o_su_data(su_data));

  // ************************************************************
  // Clock, bus tasks and checks
  // ************************************************************
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    rdv = o_rdata;
  endtask : rd

  // Waits a little past the stated latency; the mode stands meanwhile
  task automatic mode_is(input logic [1:0] m);
    repeat (3) @(posedge i_mclk);
    #1;
    check("mode", 32'(o_mode), 32'(m));
  endtask : mode_is

  task automatic req(input logic [1:0] tgt, input logic [1:0] m, input logic refused);
    wr(drvms_pkg::OFS_CMD, 32'(tgt));
    mode_is(m);
    check("refused", 32'(o_switch_refused), 32'(refused));
  endtask : req

  task automatic restore(input logic [1:0] m);
    @(posedge i_mclk);
    i_power_restored <= 1'b1;
    @(posedge i_mclk);
    i_power_restored <= 1'b0;
    mode_is(m);
  endtask : restore

  task automatic complete_run;
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (4000) @(posedge i_mclk);
    n_errors++;
    complete_run();
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    {i_resetn, i_wr, i_rd, i_power_restored} = 4'h0;
    i_addr  = 8'h00;
    i_wdata = 32'h0000_0000;
    repeat (12) @(posedge i_mclk);
    i_resetn <= 1'b1;
    mode_is(drvms_pkg::DRVMS_EXT);
    rd(drvms_pkg::OFS_STATUS);
    check("switch_ok", 32'(rdv[10:8]), 32'h0000_0003);
    req(drvms_pkg::DRVMS_PANEL, drvms_pkg::DRVMS_PANEL, 1'b0);
    req(drvms_pkg::DRVMS_NET, drvms_pkg::DRVMS_PANEL, 1'b1);
    req(drvms_pkg::DRVMS_EXT, drvms_pkg::DRVMS_EXT, 1'b0);
    req(drvms_pkg::DRVMS_NET, drvms_pkg::DRVMS_NET, 1'b0);
    check("net_wr_en", 32'(o_net_param_wr_en), 32'h0000_0001);
    wr(drvms_pkg::OFS_MODE_SEL, 32'(drvms_pkg::SEL_1));
    req(drvms_pkg::DRVMS_EXT, drvms_pkg::DRVMS_NET, 1'b1);
    wr(drvms_pkg::OFS_MODE_SEL, 32'(drvms_pkg::SEL_2));
    req(drvms_pkg::DRVMS_EXT, drvms_pkg::DRVMS_EXT, 1'b0);
    req(drvms_pkg::DRVMS_PANEL, drvms_pkg::DRVMS_EXT, 1'b1);
    req(drvms_pkg::DRVMS_COMB, drvms_pkg::DRVMS_EXT, 1'b1);
    i_panel.drive(1'b1, 1'b0, 1'b1);
    req(drvms_pkg::DRVMS_NET, drvms_pkg::DRVMS_EXT, 1'b1);
    wr(drvms_pkg::OFS_MODE_SEL, 32'(drvms_pkg::SEL_6));
    req(drvms_pkg::DRVMS_NET, drvms_pkg::DRVMS_NET, 1'b0);
    i_panel.drive(1'b0, 1'b0, 1'b0);
    wr(drvms_pkg::OFS_MODE_SEL, 32'(drvms_pkg::SEL_7));
    mode_is(drvms_pkg::DRVMS_EXT);
    i_panel.set_lock(1'b1);
    req(drvms_pkg::DRVMS_NET, drvms_pkg::DRVMS_NET, 1'b0);
    wr(drvms_pkg::OFS_MODE_SEL, 32'(drvms_pkg::SEL_0));
    wr(drvms_pkg::OFS_STARTUP, 32'(drvms_pkg::SU_NET_A));
    rd(drvms_pkg::OFS_STATUS);
    check("active_startup", 32'(rdv[7:4]), 32'h0000_0000);
    restore(drvms_pkg::DRVMS_NET);
    i_panel.startup(drvms_pkg::SU_PN_A);
    restore(drvms_pkg::DRVMS_NET);
    req(drvms_pkg::DRVMS_EXT, drvms_pkg::DRVMS_NET, 1'b1);
    i_panel.press_key();
    mode_is(drvms_pkg::DRVMS_PANEL);
    i_panel.set_link(1'b1);
    i_panel.set_link(1'b0);
    mode_is(drvms_pkg::DRVMS_NET);
    i_panel.drive(1'b1, 1'b1, 1'b0);
    repeat (2) @(posedge i_mclk);
    #1;
    check("fwd_start", 32'(o_forward_start), 32'h0000_0001);
    check("rev_start", 32'(o_reverse_start), 32'h0000_0001);
    restore(drvms_pkg::DRVMS_NET);
    check("fwd_start", 32'(o_forward_start), 32'h0000_0000);
    check("rev_start", 32'(o_reverse_start), 32'h0000_0000);
    i_panel.drive(1'b0, 1'b0, 1'b0);
    wr(drvms_pkg::OFS_COAST, 32'h0000_0064);
    i_panel.press_key();
    mode_is(drvms_pkg::DRVMS_PANEL);
    restore(drvms_pkg::DRVMS_PANEL);
    wr(drvms_pkg::OFS_COAST, 32'(drvms_pkg::COAST_NO_RST));
    wr(drvms_pkg::OFS_MODE_SEL, 32'(drvms_pkg::SEL_3));
    wr(drvms_pkg::OFS_MODE_SEL, 32'h0000_0005);
    restore(drvms_pkg::DRVMS_COMB);
    req(drvms_pkg::DRVMS_EXT, drvms_pkg::DRVMS_COMB, 1'b1);
    rd(8'hF0);
    check("unmapped", rdv, 32'h0000_0000);
    complete_run();
  end
endmodule : drvms_bench

// file: tb/drvms_panel_model.sv
// Model of the operator panel and terminal inputs of the drive.
// Assumes the bench calls its tasks; pins change just after i_mclk rises.
`timescale 1ns/1ps
module drvms_panel_model (
  input  wire logic       i_mclk,
  output logic            o_fwd,
  output logic            o_rev,
  output logic            o_run,
  output logic            o_lock,
  output logic            o_link,
  output logic            o_key,
  output logic            o_su_wr,
  output logic      [3:0] o_su_data
);
  // ************************************************************
  // Pin levels and panel actions
  // ************************************************************
  initial begin
    {o_fwd, o_rev, o_run, o_lock, o_link, o_key, o_su_wr} = 7'h00;
    o_su_data = 4'h0;
  end

  // Start inputs and motor state; still high through one selection 6 mode change
  task automatic drive(input logic f, input logic r, input logic m);
    @(posedge i_mclk);
    o_fwd <= f;
    o_rev <= r;
    o_run <= m;
  endtask : drive

  task automatic set_lock(input logic v);
    @(posedge i_mclk);
    o_lock <= v;
  endtask : set_lock

  // Panel key is one cycle long, like a debounced keypress
  task automatic press_key;
    @(posedge i_mclk);
    o_key <= 1'b1;
    @(posedge i_mclk);
    o_key <= 1'b0;
  endtask : press_key

  task automatic set_link(input logic v);
    @(posedge i_mclk);
    o_link <= v;
  endtask : set_link

  // Link settings are taken as complete before a nonzero value goes in
  task automatic startup(input logic [3:0] v);
    @(posedge i_mclk);
    o_su_wr   <= 1'b1;
    o_su_data <= v;
    @(posedge i_mclk);
    o_su_wr <= 1'b0;
  endtask : startup
endmodule : drvms_panel_model
